//--- hw/cipher_completion_flags.sv
/*
 * Completion flags of a block-cipher engine with register port, auto-clear decoding and interrupt.
 * Assumes the cipher datapath pulses done events on clk and the master obeys the strobe protocol.
 */
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
module cipher_completion_flags
	import cflag_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [DATA_W-1:0] rdata,
	input wire logic cipher_done,
	input wire logic galois_done,
	input wire logic gcm_mode,
	output logic start_pulse,
	output logic last_output_data_mode,
	output logic irq
);
	cflag_if fif();
	logic [1:0] mask_reg;
	logic lod_reg;
	logic start_reg;
	logic [DATA_W-1:0] rdata_reg;
	logic [DATA_W-1:0] rdata_next;
	logic sel_flags, sel_mask, sel_control_primary, sel_control_secondary, sel_data, sel_key, sel_ghash;
	logic start_w;

	assign sel_flags = (addr == OFF_EVENT_FLAGS);
	assign sel_mask = (addr == OFF_IRQ_MASK);
	assign sel_control_primary = (addr == OFF_CONTROL_PRIMARY);
	assign sel_control_secondary = (addr == OFF_CONTROL_SECONDARY);
	assign sel_data = (addr == OFF_CIPHER_DATA);
	assign sel_key = (addr >= OFF_HASH_KEY_LO) && (addr <= OFF_HASH_KEY_HI);
	assign sel_ghash = (addr >= OFF_GHASH_LO) && (addr <= OFF_GHASH_HI);
	assign start_w = wr && sel_control_secondary && wdata[BIT_START];

	assign fif.wr_flags = wr && sel_flags;
	assign fif.wr_data = wdata[1:0];
	assign fif.set_ev[BIT_CIPHER_DONE] = cipher_done;
	assign fif.set_ev[BIT_GALOIS_DONE] = galois_done && gcm_mode;
	assign fif.auto_clr[BIT_GALOIS_DONE] = start_w || (rd && sel_ghash);
	assign fif.auto_clr[BIT_CIPHER_DONE] = start_w
		|| (rd && sel_data && !lod_reg)
		|| (wr && sel_data && lod_reg)
		|| (rd && sel_key);

	cflag_bank u_bank (
		.clk(clk),
		.srst(srst),
		.bus(fif)
	);

	always_comb begin
		rdata_next = '0;
		if (rd && sel_flags) begin
			rdata_next = {6'h00, fif.flags};
		end else if (rd && sel_mask) begin
			rdata_next = {6'h00, mask_reg};
		end else if (rd && sel_control_primary) begin
			rdata_next = {7'h00, lod_reg};
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			mask_reg <= RST_IRQ_MASK[1:0];
			lod_reg <= RST_LOD;
			start_reg <= 1'b0;
			rdata_reg <= '0;
		end else begin
			if (wr && sel_mask) begin
				mask_reg <= wdata[1:0];
			end
			if (wr && sel_control_primary) begin
				lod_reg <= wdata[BIT_LOD];
			end
			start_reg <= start_w;
			rdata_reg <= rdata_next;
		end
	end

	assign rdata = rdata_reg;
	assign start_pulse = start_reg;
	assign last_output_data_mode = lod_reg;
	assign irq = |(fif.flags & mask_reg);

	property p_galois_set;
		@(posedge clk) disable iff (srst) (galois_done && gcm_mode) |=> fif.flags[BIT_GALOIS_DONE];
	endproperty
	a_galois_set: assert property (p_galois_set) else $error("Galois flag not set.");
	property p_cipher_set;
		@(posedge clk) disable iff (srst) cipher_done |=> fif.flags[BIT_CIPHER_DONE];
	endproperty
	a_cipher_set: assert property (p_cipher_set) else $error("Cipher flag not set.");
	property p_w1c;
		@(posedge clk) disable iff (srst) (wr && sel_flags && wdata[0] && !cipher_done) |=> !fif.flags[0];
	endproperty
	a_w1c: assert property (p_w1c) else $error("Write one did not clear.");
	property p_w0;
		@(posedge clk) disable iff (srst)
			(wr && sel_flags && !wdata[1] && fif.flags[1] && !start_w) |=> fif.flags[1];
	endproperty
	a_w0: assert property (p_w0) else $error("Write zero changed flag.");
	property p_start_g;
		@(posedge clk) disable iff (srst) (start_w && !(galois_done && gcm_mode)) |=> !fif.flags[1];
	endproperty
	a_start_g: assert property (p_start_g) else $error("Start left Galois flag.");
	property p_ghash_rd;
		@(posedge clk) disable iff (srst) (rd && sel_ghash && !(galois_done && gcm_mode)) |=> !fif.flags[1];
	endproperty
	a_ghash_rd: assert property (p_ghash_rd) else $error("Hash read left Galois flag.");
	property p_start_c;
		@(posedge clk) disable iff (srst) (start_w && !cipher_done) |=> !fif.flags[0];
	endproperty
	a_start_c: assert property (p_start_c) else $error("Start left cipher flag.");
	property p_lod0;
		@(posedge clk) disable iff (srst) (rd && sel_data && !lod_reg && !cipher_done) |=> !fif.flags[0];
	endproperty
	a_lod0: assert property (p_lod0) else $error("Data read left cipher flag.");
	property p_lod1;
		@(posedge clk) disable iff (srst)
			(rd && sel_data && lod_reg && fif.flags[0]) |=> fif.flags[0];
	endproperty
	a_lod1: assert property (p_lod1) else $error("Data read cleared flag with mode one.");
	property p_key;
		@(posedge clk) disable iff (srst) (rd && sel_key && !cipher_done) |=> !fif.flags[0];
	endproperty
	a_key: assert property (p_key) else $error("Key read left cipher flag.");
	property p_set_wins;
		@(posedge clk) disable iff (srst) (cipher_done && start_w) |=> fif.flags[0];
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("Clear beat set.");
	property p_irq;
		@(posedge clk) disable iff (srst) (wr && sel_mask && (|(wdata[1:0] & fif.flags))) |=> irq;
	endproperty
	a_irq: assert property (p_irq) else $error("Interrupt mismatch.");
	c_cipher: cover property (@(posedge clk) cipher_done ##1 (rd && sel_data));
	c_galois: cover property (@(posedge clk) (galois_done && gcm_mode) ##1 (rd && sel_ghash));
	c_irq: cover property (@(posedge clk) irq ##1 fif.wr_flags);
endmodule

//--- hw/cflag_pkg.sv
/*
 * Constants shared by the cipher completion flag block: register offsets, flag bit positions and reset values.
 * Assumes an 8-bit register port with a one-cycle read latency.
 */
package cflag_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int NUM_FLAGS = 2;
	localparam logic [7:0] OFF_EVENT_FLAGS = 8'h07;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h08;
	localparam logic [7:0] OFF_CONTROL_PRIMARY = 8'h00;
	localparam logic [7:0] OFF_CONTROL_SECONDARY = 8'h01;
	localparam logic [7:0] OFF_CIPHER_DATA = 8'h38;
	localparam logic [7:0] OFF_HASH_KEY_LO = 8'h5c;
	localparam logic [7:0] OFF_HASH_KEY_HI = 8'h6b;
	localparam logic [7:0] OFF_GHASH_LO = 8'h6c;
	localparam logic [7:0] OFF_GHASH_HI = 8'h7b;
	localparam int BIT_CIPHER_DONE = 0;
	localparam int BIT_GALOIS_DONE = 1;
	localparam int BIT_START = 0;
	localparam int BIT_LOD = 0;
	localparam logic [7:0] RST_EVENT_FLAGS = 8'h00;
	localparam logic [7:0] RST_IRQ_MASK = 8'h00;
	localparam logic RST_LOD = 1'b0;
endpackage

//--- hw/cflag_if.sv
/*
 * Interface carrying decoded register accesses from the decoder to the flag bank.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface cflag_if;
	logic wr_flags;
	logic [1:0] wr_data;
	logic [1:0] set_ev;
	logic [1:0] auto_clr;
	logic [1:0] flags;
	modport src (output wr_flags, output wr_data, output set_ev, output auto_clr, input flags);
	modport dst (input wr_flags, input wr_data, input set_ev, input auto_clr, output flags);
endinterface

//--- hw/cflag_bank.sv
/*
 * Sticky flag bank: per-bit set, write-one clear and automatic clear, with set taking precedence.
 * Assumes all inputs come from logic on the same clock.
 */
`timescale 1ns/1ps
module cflag_bank
	import cflag_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	cflag_if.dst bus
);
	logic [1:0] flags_reg;
	logic [1:0] clr_w;
	logic [1:0] flags_next;
	assign clr_w = bus.auto_clr | ({2{bus.wr_flags}} & bus.wr_data);
	assign flags_next = bus.set_ev | (flags_reg & ~clr_w);
	assign bus.flags = flags_reg;
	always_ff @(posedge clk) begin
		if (srst) begin
			flags_reg <= RST_EVENT_FLAGS[1:0];
		end else begin
			flags_reg <= flags_next;
		end
	end
endmodule

//--- tb/tb.sv
/*
 * Self-checking bench for the cipher completion flags, driven through the register port.
 * Assumes the design answers reads one cycle after the strobe and is reset synchronously.
 */
`timescale 1ns/1ps
module tb import cflag_pkg::*;;
	logic clk = 0, srst = 1, wr = 0, rd = 0, cipher_done = 0, galois_done = 0, gcm_mode = 0;
	logic [7:0] addr = 8'h00, wdata = 8'h00;
	wire logic [7:0] rdata;
	wire logic start_pulse, last_output_data_mode, irq;
	int fails = 0, checked = 0, cycles = 0;
	cipher_completion_flags dut_u (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .cipher_done(cipher_done), .galois_done(galois_done), .gcm_mode(gcm_mode),
		.start_pulse(start_pulse), .last_output_data_mode(last_output_data_mode), .irq(irq));
	initial forever #2.5 clk = ~clk;
	task summarize;
		$display("compares %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			fails++;
			summarize();
		end
	end
	task check(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask
	task wreg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1; addr <= a; wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task rreg(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		rd <= 1'b1; addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 check(rdata, exp);
	endtask
	task ev(input logic c, input logic g);
		@(posedge clk);
		cipher_done <= c; galois_done <= g;
		@(posedge clk);
		cipher_done <= 1'b0; galois_done <= 1'b0;
	endtask
	task t_set_clear;
		@(posedge clk);
		gcm_mode <= 1'b1;
		ev(1, 1);
		rreg(OFF_EVENT_FLAGS, 8'h03);
		check({7'h00, irq}, 8'h00);
		wreg(OFF_IRQ_MASK, 8'h02);
		#1 check({7'h00, irq}, 8'h01);
		rreg(OFF_IRQ_MASK, 8'h02);
		wreg(OFF_EVENT_FLAGS, 8'h00);
		rreg(OFF_EVENT_FLAGS, 8'h03);
		wreg(OFF_EVENT_FLAGS, 8'h01);
		rreg(OFF_EVENT_FLAGS, 8'h02);
		wreg(OFF_EVENT_FLAGS, 8'h02);
		rreg(OFF_EVENT_FLAGS, 8'h00);
		check({7'h00, irq}, 8'h00);
		$display("test set_clear done");
	endtask
	task t_start;
		ev(1, 1);
		wreg(OFF_CONTROL_SECONDARY, 8'h01);
		#1 check({7'h00, start_pulse}, 8'h01);
		rreg(OFF_EVENT_FLAGS, 8'h00);
		$display("test start done");
	endtask
	task t_auto;
		ev(1, 1);
		rreg(OFF_GHASH_HI, 8'h00);
		rreg(OFF_EVENT_FLAGS, 8'h01);
		rreg(OFF_HASH_KEY_LO, 8'h00);
		rreg(OFF_EVENT_FLAGS, 8'h00);
		$display("test auto_clear done");
	endtask
	task t_lod;
		ev(1, 0);
		wreg(OFF_CIPHER_DATA, 8'h55);
		rreg(OFF_EVENT_FLAGS, 8'h01);
		rreg(OFF_CIPHER_DATA, 8'h00);
		rreg(OFF_EVENT_FLAGS, 8'h00);
		wreg(OFF_CONTROL_PRIMARY, 8'h01);
		#1 check({7'h00, last_output_data_mode}, 8'h01);
		rreg(OFF_CONTROL_PRIMARY, 8'h01);
		ev(1, 0);
		rreg(OFF_CIPHER_DATA, 8'h00);
		rreg(OFF_EVENT_FLAGS, 8'h01);
		wreg(OFF_CIPHER_DATA, 8'h55);
		rreg(OFF_EVENT_FLAGS, 8'h00);
		wreg(OFF_CONTROL_PRIMARY, 8'h00);
		$display("test lod done");
	endtask
	task t_edge;
		@(posedge clk);
		gcm_mode <= 1'b0;
		ev(0, 1);
		rreg(OFF_EVENT_FLAGS, 8'h00);
		@(posedge clk);
		wr <= 1'b1; addr <= OFF_EVENT_FLAGS; wdata <= 8'h01; cipher_done <= 1'b1;
		@(posedge clk);
		wr <= 1'b0; cipher_done <= 1'b0;
		rreg(OFF_EVENT_FLAGS, 8'h01);
		rreg(8'hff, 8'h00);
		$display("test edge done");
	endtask
	initial begin
		repeat (5) @(posedge clk);
		srst <= 1'b0;
		rreg(OFF_EVENT_FLAGS, RST_EVENT_FLAGS);
		t_set_clear();
		t_start();
		t_auto();
		t_lod();
		t_edge();
		summarize();
	end
endmodule
